// ---- src/rtcu_pkg.sv ----
package rtcu_pkg;
    // instruction word layout
    localparam int RTCU_IW_W = 12;
    localparam int RTCU_ADDR_W = 5;
    localparam int RTCU_DATA_W = 8;
    localparam int RTCU_DEST_BIT = 5;
    localparam int RTCU_OP_HI = 11;
    localparam int RTCU_OP_LO = 6;
    localparam int RTCU_FILE_DEPTH = 32;
    // upper six bits of the two rotate opcodes
    localparam logic [5:0] RTCU_OP_ROT_LEFT = 6'h0D;
    localparam logic [5:0] RTCU_OP_ROT_RIGHT = 6'h0C;
    // flag bit positions
    localparam int RTCU_CARRY_BIT = 0;
    // reset values
    localparam logic [7:0] RTCU_ACC_RST = 8'h00;
    localparam logic [7:0] RTCU_FILE_RST = 8'h00;
    localparam logic [7:0] RTCU_FLAGS_RST = 8'h00;
    // cycles per rotate instruction
    localparam int RTCU_ROT_CYCLES = 1;
endpackage

// ---- src/rtcu_shifter.sv ----
`timescale 1ns/10ps
module rtcu_shifter
    import rtcu_pkg::*;
#(
    parameter int DATA_W = RTCU_DATA_W
) (
    input wire logic [DATA_W-1:0] operand,
    input wire logic carry_in,
    input wire logic dir_left,
    output logic [DATA_W-1:0] result,
    output logic carry_out
);
    // one position rotate through the carry bit
    always_comb begin
        if (dir_left) begin
            result = {operand[DATA_W-2:0], carry_in};
            carry_out = operand[DATA_W-1];
        end else begin
            result = {carry_in, operand[DATA_W-1:1]};
            carry_out = operand[0];
        end
    end
endmodule

// ---- src/rtcu_core.sv ----
`timescale 1ns/10ps
// How it works
// - left rotate: carry into bit0, bit7 out
// - right rotate: carry into bit7, bit0 out
// - destination zero writes accumulator only
// - destination one writes back file register
// - low five bits select register 0..31
module rtcu_core
    import rtcu_pkg::*;
#(
    parameter int DATA_W = RTCU_DATA_W,
    parameter int ADDR_W = RTCU_ADDR_W,
    parameter int DEPTH = RTCU_FILE_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // instruction side
    input wire logic instr_valid,
    input wire logic [RTCU_IW_W-1:0] instr_word,
    // flag load side
    input wire logic flags_load,
    input wire logic [DATA_W-1:0] flags_wdata,
    // register state seen from outside
    output logic [DATA_W-1:0] acc_value,
    output logic [DATA_W-1:0] flags_value,
    // observation port
    output logic [DATA_W-1:0] file_rdata,
    input wire logic [ADDR_W-1:0] file_raddr,
    // completion pulse
    output logic rot_done
);
    // operation kind decoded from the upper six bits
    typedef enum logic [1:0] {
        RTCU_ROTATE_NONE = 2'b00,
        RTCU_ROTATE_LEFT_VIA_CARRY = 2'b01,
        RTCU_ROTATE_RIGHT_VIA_CARRY = 2'b10
    } rtcu_kind_t;

    // accumulator and its next value
    logic [DATA_W-1:0] acc_r;
    logic [DATA_W-1:0] acc_nxt;

    // flag register and its next value
    logic [DATA_W-1:0] flags_r;
    logic [DATA_W-1:0] flags_nxt;

    // file registers, one write enable and next value per entry
    logic [DATA_W-1:0] file_r [DEPTH];
    logic [DATA_W-1:0] file_nxt [DEPTH];
    logic [DEPTH-1:0] file_we;

    // observation register and completion pulse
    logic [DATA_W-1:0] file_rdata_r;
    logic [DATA_W-1:0] file_rdata_nxt;
    logic rot_done_r;
    logic rot_done_nxt;

    // instruction fields
    logic [5:0] opcode;
    logic [ADDR_W-1:0] src_addr;
    logic dest_file;

    // decoded operation
    rtcu_kind_t op_kind;
    logic is_left;
    logic rot_go;
    logic acc_we;
    logic wb_go;

    // shifter operands and results
    logic [DATA_W-1:0] rot_operand;
    logic rot_carry_in;
    logic [DATA_W-1:0] rot_result;
    logic rot_carry;

    // split the instruction word into its fields
    assign opcode = instr_word[RTCU_OP_HI:RTCU_OP_LO];
    assign src_addr = instr_word[ADDR_W-1:0];
    assign dest_file = instr_word[RTCU_DEST_BIT];

    // only the two rotate opcodes do anything
    always_comb begin
        unique case (opcode)
            RTCU_OP_ROT_LEFT: op_kind = RTCU_ROTATE_LEFT_VIA_CARRY;
            RTCU_OP_ROT_RIGHT: op_kind = RTCU_ROTATE_RIGHT_VIA_CARRY;
            default: op_kind = RTCU_ROTATE_NONE;
        endcase
    end

    // a rotate is taken in the cycle its word is valid
    assign is_left = (op_kind == RTCU_ROTATE_LEFT_VIA_CARRY);
    assign rot_go = instr_valid && (op_kind != RTCU_ROTATE_NONE);

    // destination bit picks accumulator or write back
    assign acc_we = rot_go && !dest_file;
    assign wb_go = rot_go && dest_file;

    // selected register and old carry feed the shifter
    assign rot_operand = file_r[src_addr];
    assign rot_carry_in = flags_r[RTCU_CARRY_BIT];

    // rotate datapath
    rtcu_shifter #(
        .DATA_W(DATA_W)
    ) u_shift (
        .operand(rot_operand),
        .carry_in(rot_carry_in),
        .dir_left(is_left),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    // destination zero: result to accumulator, file untouched
    always_comb begin
        acc_nxt = acc_r;
        if (acc_we) begin
            acc_nxt = rot_result;
        end
    end

    // accumulator register
    always_ff @(posedge mclk) begin
        if (reset) begin
            acc_r <= DATA_W'(RTCU_ACC_RST);
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // destination one: only the addressed entry is written back
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_file
            assign file_we[gi] = wb_go && (src_addr == ADDR_W'(gi));

            // entry keeps its value unless written back
            always_comb begin
                file_nxt[gi] = file_r[gi];
                if (file_we[gi]) begin
                    file_nxt[gi] = rot_result;
                end
            end

            // entry register
            always_ff @(posedge mclk) begin
                if (reset) begin
                    file_r[gi] <= DATA_W'(RTCU_FILE_RST);
                end else begin
                    file_r[gi] <= file_nxt[gi];
                end
            end
        end
    endgenerate

    // rotate changes carry only and wins over a flag load
    always_comb begin
        flags_nxt = flags_r;
        if (rot_go) begin
            flags_nxt[RTCU_CARRY_BIT] = rot_carry;
        end else if (flags_load) begin
            flags_nxt = flags_wdata;
        end
    end

    // flag register
    always_ff @(posedge mclk) begin
        if (reset) begin
            flags_r <= DATA_W'(RTCU_FLAGS_RST);
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // observation read and completion pulse, both one cycle late
    always_comb begin
        file_rdata_nxt = file_r[file_raddr];
        rot_done_nxt = rot_go;
    end

    // observation register
    always_ff @(posedge mclk) begin
        if (reset) begin
            file_rdata_r <= DATA_W'(RTCU_FILE_RST);
        end else begin
            file_rdata_r <= file_rdata_nxt;
        end
    end

    // completion pulse register
    always_ff @(posedge mclk) begin
        if (reset) begin
            rot_done_r <= 1'b0;
        end else begin
            rot_done_r <= rot_done_nxt;
        end
    end

    // outputs straight from the registers
    assign acc_value = acc_r;
    assign flags_value = flags_r;
    assign file_rdata = file_rdata_r;
    assign rot_done = rot_done_r;
endmodule

// ---- test/rtcu_core_chk.sv ----
`timescale 1ns/10ps
module rtcu_core_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire logic rot_done,
    input wire logic [11:0] instr_word,
    input wire logic [7:0] flags_value,
    input wire logic [7:0] acc_value
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // t rotate taken, l left, w result to acc, c carry
    logic t, l, w, c;
    assign t = instr_valid && instr_word[11:7] == 5'h06;
    assign l = t && instr_word[6];
    assign w = t && !instr_word[5];
    assign c = flags_value[0];
    left_in_a: assert property (l && w |=> acc_value[0] == $past(c))
        else $error("left carry in");
    right_in_a: assert property (w && !l |=> acc_value[7] == $past(c))
        else $error("right carry in");
    acc_keep_a: assert property (t && !w |=> $stable(acc_value))
        else $error("acc changed");
    done_set_a: assert property (t |=> rot_done) else $error("no done");
    done_clr_a: assert property (!t |=> !rot_done) else $error("done");
    flag_keep_a: assert property (t |=> $stable(flags_value[7:1]))
        else $error("flags changed");
    cover property (l ##1 t && !l);
    cover property (t && !w);
    cover property (w && !l);
endmodule
bind rtcu_core rtcu_core_chk u_chk (.*);

// ---- test/rotate_through_carry_unit_bench.sv ----
`timescale 1ns/10ps
module rotate_through_carry_unit_bench;
    logic mclk = 0, reset = 1, instr_valid = 0, flags_load = 0, rot_done;
    logic [11:0] instr_word = 0, w;
    logic [7:0] flags_wdata = 0, acc_value, flags_value, file_rdata;
    logic [4:0] file_raddr = 0, ra;
    logic [7:0] ea = 0, ef = 0, fw, q, m[32] = '{default: 0};
    logic [7:0] ex_reg = 8'he6;
    logic iv, fl;
    int n_mismatch = 0, compares = 0;
    rtcu_core DUT (.*);
    // free running clock
    initial forever #10 mclk = ~mclk;
    // expected {carry, value} after one rotate
    function automatic logic [8:0] rot9(logic left, logic [7:0] v,
                                        logic c);
        return left ? {v, c} : {v[0], c, v[7:1]};
    endfunction
    // one comparison with its own mismatch line
    task automatic chk(string nm, logic [24:0] e, logic [24:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // one cycle: drive now, update the model, check at next fall
    task automatic step(logic v, logic [11:0] iw, logic l,
                        logic [7:0] d, logic [4:0] a);
        logic t;
        logic [8:0] x;
        logic [7:0] eq;
        instr_valid = v;
        instr_word = iw;
        flags_load = l;
        flags_wdata = d;
        file_raddr = a;
        t = v && iw[11:7] == 5'h06;
        x = rot9(iw[6], m[iw[4:0]], ef[0]);
        eq = m[a];
        if (t && iw[5]) m[iw[4:0]] = x[7:0];
        if (t && !iw[5]) ea = x[7:0];
        ef = t ? {ef[7:1], x[8]} : l ? d : ef;
        @(negedge mclk);
        chk("state", {ea, ef, eq, t},
            {acc_value, flags_value, file_rdata, rot_done});
    endtask
    // counts and verdict
    task results;
        $display("%0d compares %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h7178));
        repeat (16) @(negedge mclk);
        reset = 0;
        // corner: build 1110_0110 in entry 1, one carry load per bit
        for (int i = 7; i >= 0; i--) begin
            step(0, 12'h000, 1, {7'h00, ex_reg[i]}, 5'h01);
            step(1, 12'h361, 0, 8'h00, 5'h01);
        end
        // corner: left then right rotate of it into the accumulator
        step(0, 12'h000, 1, 8'h00, 5'h01);
        step(1, 12'h341, 0, 8'h00, 5'h01);
        chk("left acc", {16'h0000, 8'hcc, 1'b1},
            {16'h0000, acc_value, flags_value[0]});
        step(0, 12'h000, 1, 8'h00, 5'h01);
        step(1, 12'h301, 0, 8'h00, 5'h01);
        chk("right acc", {16'h0000, 8'h73, 1'b0},
            {16'h0000, acc_value, flags_value[0]});
        // corner: nine back to back right rotates restore entry 1
        repeat (9) step(1, 12'h321, 0, 8'h00, 5'h01);
        step(0, 12'h000, 0, 8'h00, 5'h01);
        chk("nine rotates", {16'h0000, 8'he6, 1'b0},
            {16'h0000, file_rdata, flags_value[0]});
        $display("corner test done");
        // mid-run reset clears every register
        reset = 1;
        repeat (2) @(negedge mclk);
        reset = 0;
        ea = 0;
        ef = 0;
        m = '{default: 0};
        step(0, 12'h000, 0, 8'h00, 5'h01);
        $display("reset test done");
        // random words, a quarter with any opcode, source walks 0..31
        for (int k = 0; k < 500; k++) begin
            {fl, fw, ra} = 14'($urandom);
            {iv, q} = 9'($urandom);
            w = {k % 4 ? 5'h06 : q[4:0], q[6:5], 5'(k)};
            step(iv, w, fl, fw, ra);
        end
        $display("random test done");
        results();
    end
endmodule
